// ==== src/igs_defines.svh ====
// Offsets, field positions, reset values and timing counts of the sensor core
`ifndef IGS_DEFINES_SVH
`define IGS_DEFINES_SVH
`define IGS_SLAVE_ADDR 7'h55
`define IGS_REG_STATUS 8'h00
`define IGS_REG_PWR 8'h01
`define IGS_REG_SETUP 8'h11
`define IGS_PWR_RESET 8'h00
`define IGS_SETUP_RESET 8'h00
`define IGS_STATUS_RESET 8'h00
`define IGS_PWR_SOFT_BIT 0
`define IGS_SETUP_MODE_BIT 0
`define IGS_SETUP_EC_MSB 3
`define IGS_SETUP_EC_LSB 1
`define IGS_FIELD_NONE 2'h0
`define IGS_CLK_MHZ 100
`define IGS_ALERT_TIME_MS 10
`define IGS_ALERT_CYCLES (`IGS_ALERT_TIME_MS * 1000 * `IGS_CLK_MHZ)
`define IGS_SLOW_DIV 512
`define IGS_FAST_DIV 8
`endif

// ==== src/igs_pkg.sv ====
// Types shared by the sensor core and its serial slave
package igs_pkg;
    // One register write taken from the serial port
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } igs_wr_s;
    // Detection results as presented by the detection logic
    typedef struct packed {
        logic [1:0] prox;
        logic [1:0] motion;
    } igs_result_s;
    // Serial slave byte-level states
    typedef enum logic [3:0] {
        IGS_IDLE, IGS_ADDR, IGS_ADDR_ACK, IGS_REG, IGS_REG_ACK,
        IGS_DATA, IGS_DATA_ACK, IGS_RD, IGS_RD_ACK
    } igs_state_e;
endpackage

// ==== src/igs_i2c_slave.sv ====
// Serial two-wire slave: address match, register pointer, write and read bytes
`timescale 1ns/1ns
`include "igs_defines.svh"
module igs_i2c_slave import igs_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] rd_data_i,
    output logic sda_oe_o,
    output logic wr_valid_o,
    output igs_wr_s wr_o,
    output logic rd_stb_o,
    output logic [7:0] rd_addr_o
);
    logic [2:0] scl_q, sda_q; // Two sync stages plus one history stage
    igs_state_e st_r;
    logic [3:0] cnt_r; // Bits taken in the current byte
    logic [7:0] sh_r, tx_r, ptr_r;
    logic rw_r;
    logic scl_rise, scl_fall, start_det, stop_det;

    // Pins are asynchronous; only stages 1 and 2 feed any logic
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], scl_i};
            sda_q <= {sda_q[1:0], sda_i};
        end
    end
    assign scl_rise = scl_q[1] & ~scl_q[2];
    assign scl_fall = ~scl_q[1] & scl_q[2];
    assign start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    assign stop_det = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

    // Byte sequencer; SDA changes after SCL falls, or is released at a start or stop
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= IGS_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            sda_oe_o <= 1'b0;
            wr_valid_o <= 1'b0;
            wr_o <= '0;
            rd_stb_o <= 1'b0;
            rd_addr_o <= 8'h00;
        end else begin
            wr_valid_o <= 1'b0;
            rd_stb_o <= 1'b0;
            if (start_det) begin // Also a repeated start
                st_r <= IGS_ADDR;
                cnt_r <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (stop_det) begin
                st_r <= IGS_IDLE;
                sda_oe_o <= 1'b0;
            end else if (scl_rise) begin
                sh_r <= {sh_r[6:0], sda_q[1]}; // MSB first
                cnt_r <= cnt_r + 4'h1;
                if (st_r == IGS_RD_ACK && sda_q[1]) begin
                    st_r <= IGS_IDLE; // Master declined more data
                end
            end else if (scl_fall) begin
                unique case (st_r)
                    IGS_IDLE: ;
                    IGS_ADDR: if (cnt_r == 4'h8) begin
                        if (sh_r[7:1] == `IGS_SLAVE_ADDR) begin
                            sda_oe_o <= 1'b1;
                            rw_r <= sh_r[0];
                            st_r <= IGS_ADDR_ACK;
                        end else begin
                            st_r <= IGS_IDLE;
                        end
                    end
                    IGS_ADDR_ACK: begin
                        cnt_r <= 4'h0;
                        if (rw_r) begin
                            sda_oe_o <= ~rd_data_i[7];
                            tx_r <= {rd_data_i[6:0], 1'b0};
                            rd_stb_o <= 1'b1;
                            rd_addr_o <= ptr_r;
                            st_r <= IGS_RD;
                        end else begin
                            sda_oe_o <= 1'b0;
                            st_r <= IGS_REG;
                        end
                    end
                    IGS_REG: if (cnt_r == 4'h8) begin
                        sda_oe_o <= 1'b1;
                        ptr_r <= sh_r;
                        rd_addr_o <= sh_r; // Read mux settles on the new pointer before any load
                        st_r <= IGS_REG_ACK;
                    end
                    IGS_REG_ACK, IGS_DATA_ACK: begin
                        sda_oe_o <= 1'b0;
                        cnt_r <= 4'h0;
                        st_r <= IGS_DATA;
                    end
                    IGS_DATA: if (cnt_r == 4'h8) begin
                        sda_oe_o <= 1'b1;
                        wr_valid_o <= 1'b1;
                        wr_o <= '{addr: ptr_r, data: sh_r};
                        st_r <= IGS_DATA_ACK;
                    end
                    IGS_RD: if (cnt_r == 4'h8) begin
                        sda_oe_o <= 1'b0; // Free SDA for master ack
                        st_r <= IGS_RD_ACK;
                    end else begin
                        sda_oe_o <= ~tx_r[7];
                        tx_r <= {tx_r[6:0], 1'b0};
                    end
                    IGS_RD_ACK: begin // Acked: send the same register again
                        cnt_r <= 4'h0;
                        sda_oe_o <= ~rd_data_i[7];
                        tx_r <= {rd_data_i[6:0], 1'b0};
                        rd_stb_o <= 1'b1;
                        rd_addr_o <= ptr_r;
                        st_r <= IGS_RD;
                    end
                endcase
            end
        end
    end
endmodule

// ==== src/igs_core.sv ====
// Sensor digital core: registers, alert, emitter pacing and shutdown
// Behaviour
// - Answer only slave address 1010101
// - Address LSB: 0 write, 1 read
// - Start condition begins address comparison
// - Address sampled MSB first on SCL high
// - Acknowledge a matching address byte
// - Acknowledge the register address byte
// - Acknowledge every data byte; store it only at 01h or 11h
// - Stop condition ends the transfer
// - Repeated start read returns pointed register; only 00h status reads back, 01h and 11h read as 00h
// - Decode 00h status, 01h power, 11h setup
// - Proximity field: 01 away, 10 near
// - Motion field: 01 two-to-one, 10 reverse
// - Soft powerdown bit, resets into shutdown
// - Setup bits 3:1 pick emitter current
// - Setup bit 0: motion or proximity
// - Alert falls when a result changes
// - Status read releases the alert
// - Alert self-releases after 10 ms
// - Emitter duty 1/512, 1/8 in motion mode when motion is active
// - Shutdown keeps all register contents
// - Powerdown pin low forces hardware shutdown
`timescale 1ns/1ns
`include "igs_defines.svh"
module igs_core import igs_pkg::*; #(
    parameter int unsigned ALERT_CYCLES = `IGS_ALERT_CYCLES
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic HW_POWERDOWN_N_PIN_I,
    input wire logic [1:0] PROXIMITY_RESULT_FIELD_I,
    input wire logic [1:0] MOTION_DIRECTION_FIELD_I,
    input wire logic MOTION_ACTIVE_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    output logic EVENT_ALERT_N_PIN_O,
    output logic EMITTER_PULSE_O,
    output logic [2:0] EMITTER_CURRENT_SELECT_O,
    output logic PROXIMITY_MODE_O,
    output logic POWERDOWN_O
);
    // Time figures turned into clock counts
    localparam int unsigned ALERT_W = $clog2(ALERT_CYCLES + 1);
    localparam logic [ALERT_W-1:0] ALERT_LAST = ALERT_W'(ALERT_CYCLES - 1);
    localparam int unsigned SLOW_W = $clog2(`IGS_SLOW_DIV);
    localparam int unsigned FAST_W = $clog2(`IGS_FAST_DIV);
    localparam logic [1:0] FIELD_NONE = `IGS_FIELD_NONE;

    // Serial slave side
    logic wr_valid; // One-cycle write strobe
    igs_wr_s wr; // Write address and data
    logic rd_stb; // One-cycle read-load strobe
    logic [7:0] rd_addr; // Register being read
    logic [7:0] rd_data; // Value offered to the slave

    // Stored registers
    logic [7:0] pwr_r; // Power-down control
    logic [7:0] setup_r; // Sensing setup
    logic [7:0] status_r; // Proximity and motion results
    logic [7:0] status_nxt;

    // Shutdown and alert state
    logic [1:0] pin_q; // Powerdown pin synchroniser
    logic pd_r; // Combined powerdown, registered
    logic pd_nxt;
    logic alert_n_r; // Alert pin level
    logic [ALERT_W-1:0] alert_tmr_r; // Time the alert has been low
    logic res_change; // A result field changes this cycle
    logic status_read; // Status register just read

    // Emitter pacing
    logic [SLOW_W-1:0] emit_cnt_r; // Free pacing counter
    logic emit_r; // Emitter strobe
    logic emit_nxt;
    logic fast_mode; // Motion mode with activity

    // Slave instance; the register pointer lives there
    igs_i2c_slave u_slave (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .scl_i(SCL_I),
        .sda_i(SDA_I),
        .rd_data_i(rd_data),
        .sda_oe_o(SDA_OE_O),
        .wr_valid_o(wr_valid),
        .wr_o(wr),
        .rd_stb_o(rd_stb),
        .rd_addr_o(rd_addr)
    );

    // Open-drain: the data level is always low, only the enable moves
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            SDA_O <= 1'b0;
        end else begin
            SDA_O <= 1'b0;
        end
    end

    // Read mux; write-only registers read back as zero
    always_comb begin
        if (rd_addr == `IGS_REG_STATUS) begin
            rd_data = status_r;
        end else begin
            rd_data = 8'h00;
        end
    end

    // Power-down control register
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pwr_r <= `IGS_PWR_RESET; // Starts in soft shutdown
        end else if (wr_valid && wr.addr == `IGS_REG_PWR) begin
            pwr_r <= wr.data;
        end
    end

    // Sensing setup register; other addresses leave it alone
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            setup_r <= `IGS_SETUP_RESET;
        end else if (wr_valid && wr.addr == `IGS_REG_SETUP) begin
            setup_r <= wr.data;
        end
    end

    // Powerdown pin is asynchronous: two stages before use
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pin_q <= 2'h0;
        end else begin
            pin_q <= {pin_q[0], HW_POWERDOWN_N_PIN_I};
        end
    end

    // Either shutdown source stops sensing; registers keep their values
    assign pd_nxt = ~pin_q[1] | ~pwr_r[`IGS_PWR_SOFT_BIT];

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pd_r <= 1'b1;
        end else begin
            pd_r <= pd_nxt;
        end
    end

    // Only the field of the chosen mode is live; the other reads as none (00)
    always_comb begin
        status_nxt = status_r;
        if (!pd_r) begin // Held while shut down
            if (setup_r[`IGS_SETUP_MODE_BIT]) begin
                status_nxt = {4'h0, PROXIMITY_RESULT_FIELD_I, FIELD_NONE};
            end else begin
                status_nxt = {4'h0, FIELD_NONE, MOTION_DIRECTION_FIELD_I};
            end
        end
    end

    // Status register capture
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            status_r <= `IGS_STATUS_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    assign res_change = (status_nxt[3:0] != status_r[3:0]);
    assign status_read = rd_stb && (rd_addr == `IGS_REG_STATUS);

    // Alert pin: a change wins over a read or timeout in the same cycle
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            alert_n_r <= 1'b1;
            alert_tmr_r <= '0;
        end else if (res_change) begin
            alert_n_r <= 1'b0;
            alert_tmr_r <= '0; // A fresh event restarts the time-out
        end else if (!alert_n_r) begin
            if (status_read) begin
                alert_n_r <= 1'b1;
                alert_tmr_r <= '0;
            end else if (alert_tmr_r == ALERT_LAST) begin
                alert_n_r <= 1'b1;
                alert_tmr_r <= '0;
            end else begin
                alert_tmr_r <= alert_tmr_r + 1'b1;
            end
        end
    end

    // Emitter pacing: one strobe per 512 cycles, or per 8 in motion mode when motion is active
    assign fast_mode = ~setup_r[`IGS_SETUP_MODE_BIT] & MOTION_ACTIVE_I;

    always_comb begin
        if (pd_r) begin
            emit_nxt = 1'b0; // No light while shut down
        end else if (fast_mode) begin
            emit_nxt = (emit_cnt_r[FAST_W-1:0] == '0);
        end else begin
            emit_nxt = (emit_cnt_r == '0);
        end
    end

    // Counter is free running so switching rate never loses phase badly
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            emit_cnt_r <= '0;
            emit_r <= 1'b0;
        end else begin
            emit_cnt_r <= emit_cnt_r + 1'b1;
            emit_r <= emit_nxt;
        end
    end

    // Output flops for the pins and the analog controls
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            EVENT_ALERT_N_PIN_O <= 1'b1;
            EMITTER_PULSE_O <= 1'b0;
            EMITTER_CURRENT_SELECT_O <= 3'h0;
            PROXIMITY_MODE_O <= 1'b0;
            POWERDOWN_O <= 1'b1;
        end else begin
            EVENT_ALERT_N_PIN_O <= alert_n_r;
            EMITTER_PULSE_O <= emit_r;
            EMITTER_CURRENT_SELECT_O <= setup_r[`IGS_SETUP_EC_MSB:`IGS_SETUP_EC_LSB];
            PROXIMITY_MODE_O <= setup_r[`IGS_SETUP_MODE_BIT];
            POWERDOWN_O <= pd_r;
        end
    end

    // Checks on the register, alert and pacing behaviour
    sequence s_change;
        res_change;
    endsequence

    sequence s_quiet_read;
        status_read && !res_change && !alert_n_r;
    endsequence

    property p_alert_on_change;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_change |=> !alert_n_r ##1 !EVENT_ALERT_N_PIN_O;
    endproperty
    a_alert_on_change: assert property (p_alert_on_change)
        else $error("alert did not fall after a result change");

    property p_alert_read;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_quiet_read |=> alert_n_r ##1 EVENT_ALERT_N_PIN_O;
    endproperty
    a_alert_read: assert property (p_alert_read)
        else $error("alert not released by status read");

    property p_alert_timeout;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (!alert_n_r && alert_tmr_r == ALERT_LAST && !res_change) |=> alert_n_r;
    endproperty
    a_alert_timeout: assert property (p_alert_timeout)
        else $error("alert not released after time-out");

    property p_alert_bound;
        @(posedge CLK_I) disable iff (!RST_B_I)
        !alert_n_r |-> alert_tmr_r <= ALERT_LAST;
    endproperty
    a_alert_bound: assert property (p_alert_bound)
        else $error("alert timer ran past its limit");

    property p_pwr_write;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (wr_valid && wr.addr == `IGS_REG_PWR) |=> ##1
            (pd_r == (~$past(wr.data[0], 2) | ~$past(pin_q[1])));
    endproperty
    a_pwr_write: assert property (p_pwr_write)
        else $error("soft powerdown bit not applied");

    // A power-down write must not reach the setup register
    property p_pwr_decode;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (wr_valid && wr.addr == `IGS_REG_PWR) |=> $stable(setup_r);
    endproperty
    a_pwr_decode: assert property (p_pwr_decode)
        else $error("power-down write reached the setup register");

    // Open drain: whenever the pad is enabled it may only pull low
    property p_sda_low;
        @(posedge CLK_I) disable iff (!RST_B_I)
        SDA_OE_O |-> !SDA_O;
    endproperty
    a_sda_low: assert property (p_sda_low)
        else $error("data line driven high");

    property p_setup_write;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (wr_valid && wr.addr == `IGS_REG_SETUP) |=> ##1
            (EMITTER_CURRENT_SELECT_O == $past(wr.data[3:1], 2)) &&
            (PROXIMITY_MODE_O == $past(wr.data[0], 2));
    endproperty
    a_setup_write: assert property (p_setup_write)
        else $error("setup write not reflected on outputs");

    // Result capture goes on; only the write itself must leave no trace
    property p_ignore_write;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (wr_valid && wr.addr != `IGS_REG_PWR && wr.addr != `IGS_REG_SETUP)
            |=> $stable(pwr_r) && $stable(setup_r) && (status_r == $past(status_nxt));
    endproperty
    a_ignore_write: assert property (p_ignore_write)
        else $error("stray write changed a register");

    property p_hold_in_pd;
        @(posedge CLK_I) disable iff (!RST_B_I)
        pd_r |=> $stable(status_r) && !emit_r;
    endproperty
    a_hold_in_pd: assert property (p_hold_in_pd)
        else $error("status or emitter moved in shutdown");

    property p_pin_pd;
        @(posedge CLK_I) disable iff (!RST_B_I)
        !pin_q[1] |=> pd_r ##1 POWERDOWN_O;
    endproperty
    a_pin_pd: assert property (p_pin_pd)
        else $error("powerdown pin did not force shutdown");

    property p_slow_rate;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (emit_r && !fast_mode) ##1 !fast_mode[*8] |-> !$past(emit_r, 1);
    endproperty
    a_slow_rate: assert property (p_slow_rate)
        else $error("slow emitter strobe came too soon");

    // Eight cycles after a fast strobe the next one is due
    property p_fast_rate;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (emit_nxt && fast_mode && !pd_r) ##1 (fast_mode && !pd_r)[*8]
            |-> emit_nxt;
    endproperty
    a_fast_rate: assert property (p_fast_rate)
        else $error("fast emitter strobe period is not eight");

    property p_mode_field;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (!pd_r && setup_r[0]) |=> status_r[1:0] == FIELD_NONE;
    endproperty
    a_mode_field: assert property (p_mode_field)
        else $error("motion field live in proximity mode");
endmodule

// ==== test/igs_master_model.sv ====
// Bus master model: a microcontroller driving the two-wire port
`timescale 1ns/1ns
`include "igs_defines.svh"
module igs_master_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // Half bit time in clocks, well above the 4-clock minimum
    localparam int HALF = 10;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Every pin change lands just after a clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Start or repeated start: data falls while clock is high
    task automatic start();
        sda_o <= 1'b1;
        tick(HALF);
        scl_o <= 1'b1;
        tick(HALF);
        sda_o <= 1'b0;
        tick(HALF);
        scl_o <= 1'b0;
        tick(2);
    endtask
    // Stop: data rises while clock is high
    task automatic stop();
        sda_o <= 1'b0;
        tick(HALF);
        scl_o <= 1'b1;
        tick(HALF);
        sda_o <= 1'b1;
        tick(HALF);
    endtask
    // One clock pulse; data stays put until two clocks after clock falls
    task automatic clk_bit(input logic b, output logic seen);
        sda_o <= b;
        tick(HALF);
        scl_o <= 1'b1;
        tick(HALF);
        seen = sda_i;
        scl_o <= 1'b0;
        tick(2);
    endtask
    // Byte out MSB first, then release the line for the acknowledge
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
    // Byte in MSB first, then acknowledge (0) or refuse (1)
    task automatic get_byte(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            v[i] = s;
        end
        clk_bit(last, s);
    endtask
    // Register write; abandons the transfer when the address is refused
    task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                      output logic ok);
        logic a0, a1, a2;
        start();
        put_byte({dev, 1'b0}, a0);
        if (!a0) begin
            stop();
            ok = 1'b0;
            return;
        end
        put_byte(ra, a1);
        put_byte(d, a2);
        stop();
        ok = a1 & a2;
    endtask
    // Register read through a repeated start, refusing the single byte
    task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        put_byte({`IGS_SLAVE_ADDR, 1'b0}, a0);
        put_byte(ra, a1);
        start();
        put_byte({`IGS_SLAVE_ADDR, 1'b1}, a2);
        get_byte(1'b1, d);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

// ==== test/igs_core_bench.sv ====
// Self-checking bench of the sensor core driven by the master model
`timescale 1ns/1ns
`include "igs_defines.svh"
module igs_core_bench;
    // Short alert timeout, still longer than one read transfer
    localparam int unsigned ALERT_N = 3000;
    // One table row: a write and the outputs it should leave
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic [2:0] cur;
        logic mode;
        logic pd;
    } igs_row_s;
    igs_row_s rows [9];
    logic clk, rst_b, hw_pd_n, mact, sda_oe, alert_n, pulse, prox_mode, pd, ok;
    logic [1:0] prox, motion;
    logic [2:0] cur;
    logic [7:0] rdv;
    wire logic scl, sda_m, sda, sda_lvl;
    int err_count = 0;
    int n_checks = 0;
    int n;
    int unsigned cycles = 0;
    // Open-drain wire: low if the master pulls or the device drives its low level
    assign sda = sda_m & ~(sda_oe & ~sda_lvl);
    igs_master_model mm (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
    igs_core #(.ALERT_CYCLES(ALERT_N)) uut (
        .CLK_I(clk), .RST_B_I(rst_b), .SCL_I(scl), .SDA_I(sda),
        .HW_POWERDOWN_N_PIN_I(hw_pd_n), .PROXIMITY_RESULT_FIELD_I(prox),
        .MOTION_DIRECTION_FIELD_I(motion), .MOTION_ACTIVE_I(mact), .SDA_O(sda_lvl),
        .SDA_OE_O(sda_oe), .EVENT_ALERT_N_PIN_O(alert_n), .EMITTER_PULSE_O(pulse),
        .EMITTER_CURRENT_SELECT_O(cur), .PROXIMITY_MODE_O(prox_mode), .POWERDOWN_O(pd)
    );
    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Compare and count; an unknown never matches
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Emitter strobes in a window of two slow periods
    task automatic count_pulses();
        n = 0;
        repeat (1024) begin
            @(posedge clk);
            if (pulse === 1'b1) n++;
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Hang guard: the whole run needs well under half this
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        rows = '{'{8'h01, 8'h01, 3'h0, 1'b0, 1'b0}, '{8'h11, 8'h0E, 3'h7, 1'b0, 1'b0},
                 '{8'h11, 8'h03, 3'h1, 1'b1, 1'b0}, '{8'h11, 8'h05, 3'h2, 1'b1, 1'b0},
                 '{8'h00, 8'hFF, 3'h2, 1'b1, 1'b0}, '{8'h42, 8'h0F, 3'h2, 1'b1, 1'b0},
                 '{8'h01, 8'hFE, 3'h2, 1'b1, 1'b1}, '{8'h11, 8'h08, 3'h4, 1'b0, 1'b1},
                 '{8'h01, 8'h01, 3'h4, 1'b0, 1'b0}};
        rst_b <= 1'b0;
        hw_pd_n <= 1'b1;
        mact <= 1'b0;
        prox <= 2'h0;
        motion <= 2'h0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chk("alert", 8'h01, {7'h00, alert_n});
        chk("sda level", 8'h00, {7'h00, sda_lvl});
        chk("current", 8'h00, {5'h00, cur});
        chk("mode", 8'h00, {7'h00, prox_mode});
        chk("powerdown", 8'h01, {7'h00, pd});
        // Table: writes, including ignored targets and writes while shut down
        for (int k = 0; k < 9; k++) begin
            mm.wr(`IGS_SLAVE_ADDR, rows[k].addr, rows[k].data, ok);
            chk("ack", 8'h01, {7'h00, ok});
            chk("current", {5'h00, rows[k].cur}, {5'h00, cur});
            chk("mode", {7'h00, rows[k].mode}, {7'h00, prox_mode});
            chk("powerdown", {7'h00, rows[k].pd}, {7'h00, pd});
        end
        // Foreign address is refused and changes nothing
        mm.wr(7'h56, 8'h11, 8'h00, ok);
        chk("foreign ack", 8'h00, {7'h00, ok});
        chk("current", 8'h04, {5'h00, cur});
        // Motion result raises the alert; a status read clears it
        @(posedge clk);
        motion <= 2'h1;
        prox <= 2'h2;
        repeat (4) @(posedge clk);
        chk("alert", 8'h00, {7'h00, alert_n});
        mm.rd(8'h00, rdv, ok);
        chk("status", 8'h01, rdv);
        chk("alert", 8'h01, {7'h00, alert_n});
        // Proximity mode reports the other field
        mm.wr(`IGS_SLAVE_ADDR, 8'h11, 8'h01, ok);
        @(posedge clk);
        prox <= 2'h1;
        repeat (4) @(posedge clk);
        mm.rd(8'h00, rdv, ok);
        chk("status", 8'h04, rdv);
        chk("read ack", 8'h01, {7'h00, ok});
        // Unread alert lets go by itself after the timeout
        @(posedge clk);
        prox <= 2'h2;
        repeat (ALERT_N - 20) @(posedge clk);
        chk("alert held", 8'h00, {7'h00, alert_n});
        repeat (30) @(posedge clk);
        chk("alert timeout", 8'h01, {7'h00, alert_n});
        // Emitter pacing: slow in proximity, fast in active motion, none when down
        count_pulses();
        chk("slow pulses", 8'h02, n[7:0]);
        mm.wr(`IGS_SLAVE_ADDR, 8'h11, 8'h00, ok);
        @(posedge clk);
        mact <= 1'b1;
        // Let the two-stage strobe pipeline fill so the window is all fast pacing
        repeat (4) @(posedge clk);
        count_pulses();
        chk("fast pulses", 8'h80, n[7:0]);
        hw_pd_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk("hw powerdown", 8'h01, {7'h00, pd});
        count_pulses();
        chk("down pulses", 8'h00, n[7:0]);
        chk("current kept", 8'h00, {5'h00, cur});
        hw_pd_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk("powerdown", 8'h00, {7'h00, pd});
        conclude();
    end
endmodule
